// file: src/adc_device_end.sv
// Purpose: Control sequencer of the serial 10-bit converter, device end of the link
// Assumes: Link clock is idle low while select is being recognised
// Notes: Result and channel cross as quasi-static words, stable while read
//
// How it works
// - Select high: output released, inputs ignored
// - Select low recognised after filtering system clocks
// - Recognised select shows previous result MSB
// - Four-bit address captured MSB first on rises
// - First four falls shift result bits two-five
// - Sampling starts after fourth fall
// - Falls five to nine shift bits six-ten
// - Tenth fall holds, conversion takes 44 cycles
// - Host raises select or idles clock 44 cycles
// - Select may stay low; clock must be clean
// - Raised select stays high until conversion ends
// - Recognised select fall aborts running conversion
// - Early new sequence aborts, restarts, keeps old result
// - System and link clocks fully independent
// - Shared clock: link clock when select low
// - Shared clock: recognition consumes first five cycles
// - Shared clock: host raises select after eighth
// - Shared clock: extra cycles count as pulses
// - Stretched tenth pulse keeps sampling until fall
// - Result is ten bits, sent MSB first
// - Address 1011 selects mid-scale self-test input
`timescale 1ns/10ps
module adc_device_end (
   input wire logic clk_sys,
   input wire logic rst_b,
   adc_link_if.dev link,
   input wire logic shared_clk,
   input wire logic [adc_link_pkg::RES_W-1:0] analog_code,
   output logic [adc_link_pkg::ADDR_W-1:0] chan_sel,
   output logic sampling,
   output logic hold_start,
   output logic conv_done,
   output logic conv_busy,
   output logic [adc_link_pkg::RES_W-1:0] result
);
   import adc_link_pkg::*;

   typedef enum logic [1:0] {
      C_IDLE = 2'b01,
      C_CONV = 2'b10
   } conv_state_e;

   // System domain
   logic cs_s1_r, cs_s2_r, cs_low_r;
   logic [CNT_W-1:0] recog_r;
   logic st_s1_r, st_s2_r, st_s3_r, start_evt;
   conv_state_e state_r;
   logic [WAIT_W-1:0] conv_r;
   logic [ADDR_W-1:0] chan_r;
   logic [RES_W-1:0] code_r, result_r;
   logic hold_r, done_r, count_en;
   // Link domain
   logic lrst_b;
   logic [CNT_W-1:0] rise_r, fall_r;
   logic [ADDR_W-1:0] addr_r;
   logic sample_r, start_tgl_r;

   // ==========================================================
   // Select synchroniser and noise filter
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
      end else begin
         cs_s1_r <= link.cs_b;
         cs_s2_r <= cs_s1_r;
      end
   end

   // Low level counts only after it has stood for the filter length
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         recog_r <= '0;
         cs_low_r <= 1'b0;
      end else if (cs_s2_r) begin
         recog_r <= '0;
         cs_low_r <= 1'b0;
      end else if (!cs_low_r) begin
         recog_r <= recog_r + 4'h1;
         if (recog_r == CS_RECOG_CYC - 4'h1) begin
            cs_low_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Link bit counters and sampling flag, held in reset until select is recognised low
   // Reset also clears the bit counters after any abort
   assign lrst_b = rst_b & cs_low_r;

   // Address capture on the first four rises of each sequence
   // Kept through deselect: the system side reads it a few cycles after the tenth fall
   always_ff @(posedge link.io_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_r <= '0;
      end else if (cs_low_r && rise_r < ADDR_PULSES) begin
         addr_r <= {addr_r[ADDR_W-2:0], link.addr_bit};
      end
   end

   // Rise counter, cleared with the fall counter and sampling flag
   always_ff @(posedge link.io_clk or negedge lrst_b) begin
      if (!lrst_b) begin
         rise_r <= '0;
      end else begin
         // Counting never stops while select is low, so extra pulses start a new frame
         if (rise_r == SEQ_PULSES - 4'h1) begin
            rise_r <= '0;
         end else begin
            rise_r <= rise_r + 4'h1;
         end
      end
   end

   // Bit index and sampling window on falling edges
   always_ff @(negedge link.io_clk or negedge lrst_b) begin
      if (!lrst_b) begin
         fall_r <= '0;
         sample_r <= 1'b0;
      end else if (fall_r == SEQ_PULSES - 4'h1) begin
         fall_r <= '0;
         sample_r <= 1'b0;
      end else begin
         fall_r <= fall_r + 4'h1;
         if (fall_r == ADDR_PULSES - 4'h1) begin
            sample_r <= 1'b1;
         end
      end
   end

   // Start toggle survives select changes so no false start is seen
   always_ff @(negedge link.io_clk or negedge rst_b) begin
      if (!rst_b) begin
         start_tgl_r <= 1'b0;
      end else if (cs_low_r && fall_r == SEQ_PULSES - 4'h1) begin
         start_tgl_r <= ~start_tgl_r;
      end
   end

   // ==========================================================
   // Serial output; result stays still during a transfer
   // Index 0 shows the MSB as soon as select is recognised
   assign link.dout = result_r[4'(RES_W - 1) - fall_r];
   assign link.dout_oe_b = ~cs_low_r;

   // ==========================================================
   // Start event crossing, toggle into the system domain
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_s1_r <= 1'b0;
         st_s2_r <= 1'b0;
         st_s3_r <= 1'b0;
      end else begin
         st_s1_r <= start_tgl_r;
         st_s2_r <= st_s1_r;
         st_s3_r <= st_s2_r;
      end
   end

   assign start_evt = st_s2_r ^ st_s3_r;

   // With one shared clock the converter does not count while select is recognised low
   assign count_en = !(shared_clk && cs_low_r);

   // ==========================================================
   // Conversion sequencer
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= C_IDLE;
         conv_r <= '0;
         chan_r <= '0;
         code_r <= RESULT_RST;
         result_r <= RESULT_RST;
         hold_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         hold_r <= 1'b0;
         done_r <= 1'b0;
         if (start_evt) begin
            // A new sequence restarts; the old result is left in place
            state_r <= C_CONV;
            conv_r <= '0;
            chan_r <= addr_r;
            hold_r <= 1'b1;
            if (addr_r == SELF_TEST_ADDR) begin
               code_r <= SELF_TEST_CODE;
            end else begin
               code_r <= analog_code;
            end
         end else begin
            case (state_r)
               C_IDLE: begin
                  conv_r <= '0;
               end
               C_CONV: begin
                  if (cs_s2_r == 1'b0 && recog_r == CS_RECOG_CYC - 4'h1 && !cs_low_r) begin
                     // Select recognised low mid-conversion
                     state_r <= C_IDLE;
                  end else if (count_en) begin
                     conv_r <= conv_r + 8'h01;
                     if (conv_r == CONV_CYC - 8'h01) begin
                        result_r <= code_r;
                        done_r <= 1'b1;
                        state_r <= C_IDLE;
                     end
                  end
               end
               default: state_r <= C_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // User side
   assign chan_sel = chan_r;
   assign sampling = sample_r;
   assign hold_start = hold_r;
   assign conv_done = done_r;
   assign conv_busy = (state_r == C_CONV);
   assign result = result_r;
endmodule

// file: include/adc_link_pkg.sv
// Purpose: Shared constants for the serial converter link, device end and host end
// Assumes: System clock at 25 MHz, one aligned 10-bit result per transfer
// Notes: All cycle figures are counts of the clock named beside them
package adc_link_pkg;
   // ==========================================================
   // Widths
   localparam int RES_W = 10;
   localparam int ADDR_W = 4;
   localparam int CNT_W = 4;
   localparam int WAIT_W = 8;
   // ==========================================================
   // Transfer sequence, in link clock pulses
   localparam logic [CNT_W-1:0] ADDR_PULSES = 4'h4;
   localparam logic [CNT_W-1:0] SEQ_PULSES = 4'hA;
   // ==========================================================
   // System clock timing
   localparam int SYS_PERIOD_NS = 40;
   localparam logic [WAIT_W-1:0] CONV_CYC = 8'h2C;
   localparam logic [CNT_W-1:0] CS_RECOG_CYC = 4'h3;
   localparam logic [WAIT_W-1:0] CS_SETUP_CYC = 8'h08;
   localparam logic [WAIT_W-1:0] CONV_WAIT_CYC = CONV_CYC + 8'h08;
   localparam logic [CNT_W-1:0] IO_HALF_CYC = 4'h4;
   // ==========================================================
   // Self-test input
   localparam logic [ADDR_W-1:0] SELF_TEST_ADDR = 4'hB;
   localparam logic [RES_W-1:0] SELF_TEST_CODE = 10'h200;
   localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
endpackage

// file: include/adc_link_if.sv
// Purpose: Serial control link between host and converter
// Assumes: Data line has a pull-up when nobody drives it
// Notes: The shared data wire level is resolved here from the enable
`timescale 1ns/10ps
interface adc_link_if;
   logic cs_b;
   logic addr_bit;
   logic io_clk;
   logic dout;
   logic dout_oe_b;
   logic dout_line;

   // Pull-up stands in for the floating bus
   assign dout_line = dout_oe_b ? 1'b1 : dout;

   modport dev (
      input cs_b,
      input addr_bit,
      input io_clk,
      output dout,
      output dout_oe_b
   );

   modport host (
      output cs_b,
      output addr_bit,
      output io_clk,
      input dout_line
   );
endinterface

// file: src/adc_host_end.sv
// Purpose: Host end, runs one select, address, read and conversion wait cycle per request
// Assumes: Device runs on the same system clock rate
// Notes: Link clock is divided from clk_sys; shared clock mode is not driven here
`timescale 1ns/10ps
module adc_host_end (
   input wire logic clk_sys,
   input wire logic rst_b,
   adc_link_if.host link,
   input wire logic req,
   input wire logic [adc_link_pkg::ADDR_W-1:0] req_chan,
   input wire logic strobe_wait,
   output logic ready,
   output logic [adc_link_pkg::RES_W-1:0] prev_result,
   output logic result_valid
);
   import adc_link_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_SETUP = 4'b0010,
      H_SHIFT = 4'b0100,
      H_CONV = 4'b1000
   } host_state_e;

   host_state_e state_r;
   logic cs_b_r, io_r, addr_bit_r, dsync1_r, dsync2_r, valid_r;
   logic [WAIT_W-1:0] wait_r;
   logic [CNT_W-1:0] ph_r, pulse_r;
   logic [ADDR_W-1:0] addr_sh_r;
   logic [RES_W-1:0] sh_r, res_r;
   logic ph_end;

   // ==========================================================
   // Data line synchroniser
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dsync1_r <= 1'b1;
         dsync2_r <= 1'b1;
      end else begin
         dsync1_r <= link.dout_line;
         dsync2_r <= dsync1_r;
      end
   end

   assign ph_end = (ph_r == IO_HALF_CYC - 4'h1);

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= H_IDLE;
         cs_b_r <= 1'b1;
         io_r <= 1'b0;
         addr_bit_r <= 1'b0;
         wait_r <= '0;
         ph_r <= '0;
         pulse_r <= '0;
         addr_sh_r <= '0;
         sh_r <= RESULT_RST;
         res_r <= RESULT_RST;
         valid_r <= 1'b0;
      end else begin
         valid_r <= 1'b0;
         case (state_r)
            H_IDLE: begin
               if (req) begin
                  cs_b_r <= 1'b0;
                  addr_sh_r <= req_chan;
                  wait_r <= '0;
                  state_r <= H_SETUP;
               end
            end
            H_SETUP: begin
               // Device needs the setup time to recognise select before any pulse
               wait_r <= wait_r + 8'h01;
               if (wait_r == CS_SETUP_CYC - 8'h01) begin
                  ph_r <= '0;
                  pulse_r <= '0;
                  addr_bit_r <= addr_sh_r[ADDR_W-1];
                  state_r <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               ph_r <= ph_r + 4'h1;
               if (!io_r && ph_end) begin
                  io_r <= 1'b1;
                  ph_r <= '0;
                  sh_r <= {sh_r[RES_W-2:0], dsync2_r};
               end else if (io_r && ph_end) begin
                  // Last pulse may be stretched high until the hold instant
                  if (pulse_r != SEQ_PULSES - 4'h1 || !strobe_wait) begin
                     io_r <= 1'b0;
                     ph_r <= '0;
                     pulse_r <= pulse_r + 4'h1;
                     addr_sh_r <= {addr_sh_r[ADDR_W-2:0], 1'b0};
                     addr_bit_r <= addr_sh_r[ADDR_W-2];
                     if (pulse_r == SEQ_PULSES - 4'h1) begin
                        cs_b_r <= 1'b1;
                        wait_r <= '0;
                        res_r <= sh_r;
                        valid_r <= 1'b1;
                        state_r <= H_CONV;
                     end
                  end else begin
                     ph_r <= ph_r;
                  end
               end
            end
            H_CONV: begin
               // Select stays high for the whole conversion
               wait_r <= wait_r + 8'h01;
               if (wait_r == CONV_WAIT_CYC - 8'h01) begin
                  state_r <= H_IDLE;
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end

   // Link clock comes from a flop so it cannot glitch
   assign link.io_clk = io_r;
   assign link.cs_b = cs_b_r;
   assign link.addr_bit = addr_bit_r;
   assign ready = (state_r == H_IDLE);
   assign prev_result = res_r;
   assign result_valid = valid_r;
endmodule

// file: test/adc_link_monitor.sv
// Purpose: Concurrent checks on the link that joins the host end to the device end
// Assumes: Link signals are sampled as plain data on clk_sys
// Notes: Only the first link is watched; the fault link is judged by the bench
`timescale 1ns/10ps
module adc_link_monitor (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic addr_bit,
   input wire logic io_clk,
   input wire logic dout,
   input wire logic dout_oe_b,
   input wire logic dout_line
);
   import adc_link_pkg::*;

   // ==========================================================
   // Frame tracking
   logic io_r;
   logic framed_r;
   logic [3:0] fall_cnt_r;
   logic [7:0] hi_cnt_r;
   logic io_fall;
   assign io_fall = io_r & ~io_clk;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) io_r <= 1'b0;
      else io_r <= io_clk;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) fall_cnt_r <= 4'h0;
      else if (cs_b) fall_cnt_r <= 4'h0;
      else if (io_fall) fall_cnt_r <= fall_cnt_r + 4'h1;
   end
   // Saturates, so a long idle spell never wraps under the conversion time
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) hi_cnt_r <= 8'h00;
      else if (!cs_b) hi_cnt_r <= 8'h00;
      else if (hi_cnt_r != 8'hFF) hi_cnt_r <= hi_cnt_r + 8'h01;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) framed_r <= 1'b0;
      else if (io_fall && fall_cnt_r == SEQ_PULSES - 4'h1) framed_r <= 1'b1;
      else if (!cs_b) framed_r <= 1'b0;
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_idle_released: assert property (cs_b [*4] |-> dout_oe_b && dout_line)
      else $error("data line driven while deselected");
   a_select_filter: assert property ($fell(cs_b) |-> dout_oe_b [*4])
      else $error("select taken before filtering");
   a_select_taken: assert property ($fell(cs_b) ##1 !cs_b [*7] |-> !dout_oe_b)
      else $error("select never recognised");
   a_drive_hold: assert property (!dout_oe_b && !cs_b |=> !dout_oe_b)
      else $error("data line released while selected");
   a_dout_steady: assert property (!dout_oe_b && io_clk && io_r |-> $stable(dout))
      else $error("data bit changed while link clock high");
   a_host_release: assert property (io_fall && fall_cnt_r == SEQ_PULSES - 4'h1 |-> ##[0:1] cs_b)
      else $error("select kept low after tenth pulse");
   a_cs_high_hold: assert property ($fell(cs_b) && framed_r |-> hi_cnt_r >= CONV_CYC)
      else $error("select lowered during conversion");
   a_ten_pulses: assert property ($rose(cs_b) |-> framed_r || (io_fall && fall_cnt_r == SEQ_PULSES - 4'h1))
      else $error("frame ended without ten pulses");
   c_frame_done: cover property (io_fall && fall_cnt_r == SEQ_PULSES - 4'h1);
   c_strobe_hold: cover property (io_clk [*8]);
   c_addr_one: cover property ($rose(io_clk) && !cs_b && addr_bit);
endmodule

// file: test/serial_adc_control_sequencer_tb.sv
// Purpose: Self-checking bench, host end facing device end plus a fault link
// Assumes: Host end makes its own link clock; the fault link clock is made here
// Notes: Fault link breaks host-side timing on purpose to force aborts
`timescale 1ns/10ps
module serial_adc_control_sequencer_tb;
   import adc_link_pkg::*;
   logic clk_sys, rst_b, req, strobe_wait, ready, result_valid;
   logic sampling1, hs1, done1, hs2, done2, io_d, fell_d, busy1, busy2, shared2;
   logic counting = 1'b0;
   logic [ADDR_W-1:0] req_chan, chan1, chan2, ch2_r;
   logic [RES_W-1:0] prev_result, analog1, analog2, result1, result2, exp_prev, sh2, r_keep, wsh;
   logic [15:0] res_q[$], conv_q[$], chan_q[$], conv2_q[$];
   logic [15:0] conv_cnt, e1;
   logic [31:0] seed = 32'h0000EAC3;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   int fc = 0;
   int hs_cnt = 0;
   int d2_hs = 0;
   int d2_done = 0;
   adc_link_if link1();
   adc_link_if link2();
   adc_host_end i_adc_host_end (.clk_sys(clk_sys), .rst_b(rst_b), .link(link1), .req(req), .req_chan(req_chan),
      .strobe_wait(strobe_wait), .ready(ready), .prev_result(prev_result), .result_valid(result_valid));
   adc_device_end i_adc_device_end (.clk_sys(clk_sys), .rst_b(rst_b), .link(link1), .shared_clk(1'b0),
      .analog_code(analog1), .chan_sel(chan1), .sampling(sampling1), .hold_start(hs1), .conv_done(done1),
      .conv_busy(busy1), .result(result1));
   adc_device_end i_adc_device_end2 (.clk_sys(clk_sys), .rst_b(rst_b), .link(link2), .shared_clk(shared2),
      .analog_code(analog2), .chan_sel(chan2), .sampling(), .hold_start(hs2), .conv_done(done2),
      .conv_busy(busy2), .result(result2));
   adc_link_monitor i_adc_link_monitor (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(link1.cs_b),
      .addr_bit(link1.addr_bit), .io_clk(link1.io_clk), .dout(link1.dout), .dout_oe_b(link1.dout_oe_b),
      .dout_line(link1.dout_line));
   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic host_frame(input logic [ADDR_W-1:0] ch, input logic strobe);
      int n;
      int k;
      n = 0;
      while (ready !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      check(16'(link1.dout_line), 16'h0001);
      analog1 = RES_W'(rnd());
      res_q.push_back(16'(exp_prev));
      exp_prev = (ch == SELF_TEST_ADDR) ? SELF_TEST_CODE : analog1;
      conv_q.push_back(16'(exp_prev));
      chan_q.push_back(16'(ch));
      req = 1'b1;
      req_chan = ch;
      strobe_wait = strobe;
      @(negedge clk_sys);
      req = 1'b0;
      if (strobe) begin
         n = 0;
         for (k = 0; k < 200 && n < 6; k++) begin
            @(negedge clk_sys);
            n = link1.io_clk ? n + 1 : 0;
         end
         k = hs_cnt;
         repeat (20) @(negedge clk_sys);
         check(16'(sampling1), 16'h0001);
         check(16'(hs_cnt - k), 16'h0000);
         strobe_wait = 1'b0;
      end
   endtask
   // Fault link clock: 32 ns period, free of clk_sys phase, still between frames
   task automatic pulse2(input logic a);
      link2.addr_bit = a;
      #16 link2.io_clk = 1'b1;
      sh2 = {sh2[RES_W-2:0], link2.dout_line};
      #16 link2.io_clk = 1'b0;
   endtask
   task automatic frame2(input logic [ADDR_W-1:0] ch, input int n, input logic raise);
      @(negedge clk_sys);
      link2.cs_b = 1'b0;
      repeat (8) @(negedge clk_sys);
      #7;
      for (int k = 0; k < n; k++) pulse2(k < 4 ? ch[ADDR_W-1-k] : 1'b0);
      @(negedge clk_sys);
      if (raise) link2.cs_b = 1'b1;
   endtask
   // ==========================================================
   // Clock, timeout and result watcher
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         final_report();
      end
   end
   always @(posedge clk_sys) begin
      if (rst_b === 1'b1) begin
         if (result_valid === 1'b1) begin
            e1 = res_q.size() ? res_q.pop_front() : 16'hXXXX;
            check(16'(prev_result), e1);
            check(16'(wsh), e1);
         end
         if (hs1 === 1'b1) check(16'(chan1), chan_q.size() ? chan_q.pop_front() : 16'hXXXX);
         if (hs1 === 1'b1) check(16'(busy1), 16'h0001);
         if (counting) conv_cnt++;
         if (hs1 === 1'b1) begin
            conv_cnt = 16'h0000;
            counting = 1'b1;
            hs_cnt++;
         end
         if (done1 === 1'b1) begin
            check(conv_cnt, 16'(CONV_CYC));
            check(16'(busy1), 16'h0000);
            check(16'(result1), conv_q.size() ? conv_q.pop_front() : 16'hXXXX);
            counting = 1'b0;
         end
         if (fell_d && link1.cs_b === 1'b0) check(16'(sampling1), 16'(fc >= 4));
         fell_d = io_d && !link1.io_clk;
         if (!io_d && link1.io_clk) wsh = {wsh[RES_W-2:0], link1.dout_line};
         if (link1.cs_b) fc = 0;
         else if (fell_d) fc++;
         io_d = link1.io_clk;
         if (hs2 === 1'b1) begin
            d2_hs++;
            ch2_r = chan2;
         end
         if (done2 === 1'b1) d2_done++;
         if (done2 === 1'b1) check(16'(result2), conv2_q.size() ? conv2_q.pop_front() : 16'hXXXX);
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      req = 1'b0;
      req_chan = '0;
      strobe_wait = 1'b0;
      analog1 = '0;
      analog2 = '0;
      shared2 = 1'b0;
      io_d = 1'b0;
      fell_d = 1'b0;
      link2.cs_b = 1'b1;
      link2.io_clk = 1'b0;
      link2.addr_bit = 1'b0;
      exp_prev = RESULT_RST;
      repeat (2) @(negedge clk_sys);
      rst_b = 1'b1;
      for (int i = 0; i < 6; i++) begin
         host_frame((i == 2) ? SELF_TEST_ADDR : ADDR_W'(rnd()), i == 4);
         $display("host frame %0d done", i);
      end
      host_frame(4'h0, 1'b0);
      analog2 = RES_W'(rnd());
      r_keep = analog2;
      conv2_q.push_back(16'(analog2));
      frame2(4'h5, 10, 1'b1);
      repeat (60) @(negedge clk_sys);
      check(16'(d2_done), 16'h0001);
      check(16'(ch2_r), 16'h0005);
      $display("fault link baseline done");
      analog2 = ~r_keep;
      frame2(4'h6, 10, 1'b1);
      repeat (10) @(negedge clk_sys);
      link2.cs_b = 1'b0;
      repeat (10) @(negedge clk_sys);
      link2.cs_b = 1'b1;
      repeat (60) @(negedge clk_sys);
      check(16'(d2_done), 16'h0001);
      check(16'(result2), 16'(r_keep));
      check(16'(busy2), 16'h0000);
      $display("select abort done");
      frame2(4'h7, 10, 1'b0);
      check(16'(sh2), 16'(r_keep));
      analog2 = RES_W'(rnd());
      conv2_q.push_back(16'(analog2));
      frame2(4'h8, 10, 1'b1);
      check(16'(sh2), 16'(r_keep));
      repeat (60) @(negedge clk_sys);
      check(16'(d2_done), 16'h0002);
      check(16'(d2_hs), 16'h0004);
      $display("restart abort done");
      analog2 = ~SELF_TEST_CODE;
      for (int k = 0; k < 5; k++) pulse2(1'b1);
      check(16'(link2.dout_line), 16'h0001);
      frame2(4'h9, 3, 1'b1);
      repeat (10) @(negedge clk_sys);
      conv2_q.push_back(16'(SELF_TEST_CODE));
      frame2(SELF_TEST_ADDR, 10, 1'b1);
      repeat (60) @(negedge clk_sys);
      check(16'(ch2_r), 16'(SELF_TEST_ADDR));
      check(16'(d2_done), 16'h0003);
      $display("counter clear done");
      // Shared clock: conversion waits while select is still seen low
      shared2 = 1'b1;
      analog2 = RES_W'(rnd());
      conv2_q.push_back(16'(analog2));
      frame2(4'h2, 10, 1'b0);
      repeat (60) @(negedge clk_sys);
      check(16'(d2_done), 16'h0003);
      check(16'(busy2), 16'h0001);
      link2.cs_b = 1'b1;
      repeat (60) @(negedge clk_sys);
      check(16'(d2_done), 16'h0004);
      analog2 = RES_W'(rnd());
      conv2_q.push_back(16'(analog2));
      frame2(4'h3, 8, 1'b0);
      link2.cs_b = 1'b1;
      pulse2(1'b0);
      pulse2(1'b0);
      repeat (60) @(negedge clk_sys);
      check(16'(d2_done), 16'h0005);
      check(16'(ch2_r), 16'h0003);
      $display("shared clock done");
      final_report();
   end
endmodule
